// ### rtl/gpt_pkg.sv
// Package with register map, field layout and modes of the timer set.
`default_nettype none
package gpt_pkg;
  // Counter widths and timer count.
  localparam int unsigned GP_W = 16;
  localparam int unsigned BT_W = 8;
  localparam int unsigned NGP = 2;
  localparam int unsigned GP_PSC_W = 7;
  localparam int unsigned BT_PSC_W = 15;
  // Byte offsets of the registers.
  localparam logic [7:0] GP_STRIDE = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ARR = 8'h04;
  localparam logic [7:0] OFS_CNT = 8'h08;
  localparam logic [7:0] OFS_CC0 = 8'h0C;
  localparam logic [7:0] OFS_CC1 = 8'h10;
  localparam logic [7:0] OFS_CCM = 8'h14;
  localparam logic [7:0] BT_CTRL = 8'h40;
  localparam logic [7:0] BT_ARR = 8'h44;
  localparam logic [7:0] BT_CNT = 8'h48;
  localparam logic [7:0] REG_STAT = 8'h50;
  localparam logic [7:0] REG_IEN = 8'h54;
  localparam logic [7:0] REG_ICLR = 8'h58;
  localparam logic [7:0] REG_DMA = 8'h5C;
  // Control fields of a general-purpose timer.
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_DOWN = 1;
  localparam int unsigned PSC_LSB = 2;
  localparam int unsigned PSC_W = 3;
  localparam int unsigned SYNC_LSB = 5;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned CCM_W = 4;
  // Control fields of the basic timer.
  localparam int unsigned BT_PSC_LSB = 1;
  localparam int unsigned BT_EXP_W = 4;
  localparam int unsigned BT_CTRL_W = 5;
  // Event bits, five per general-purpose timer, then the basic timer.
  localparam int unsigned EV_OVF = 0;
  localparam int unsigned EV_CC0 = 1;
  localparam int unsigned EV_TRG = 3;
  localparam int unsigned EV_BRK = 4;
  localparam int unsigned EV_N = 5;
  localparam int unsigned ST_BT = 10;
  localparam int unsigned ST_W = 11;
  // Reset values.
  localparam logic [GP_W-1:0] GP_ARR_RST = 16'hFFFF;
  localparam logic [BT_W-1:0] BT_ARR_RST = 8'hFF;
  // Synchronisation modes and channel modes.
  typedef enum logic [2:0] {SYNC_NONE, SYNC_EXTCLK, SYNC_RESET, SYNC_GATE, SYNC_START,
    SYNC_R5, SYNC_R6, SYNC_R7} gpt_sync_e;
  typedef enum logic [1:0] {CH_OFF, CH_TOGGLE, CH_PWM, CH_CAPTURE} gpt_chm_e;
endpackage
`default_nettype wire

// ### rtl/gpt_top.sv
// Timer set: two general-purpose timers, one basic timer, APB registers.
`default_nettype none
module gpt_top #(
  parameter int unsigned GPW = gpt_pkg::GP_W,
  parameter int unsigned BTW = gpt_pkg::BT_W
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Timer pins.
  input wire logic gp_timer_a_ext_trigger_i,
  input wire logic break_i,
  input wire logic [1:0] gpa_cap_i,
  input wire logic gpb_cap_i,
  output logic [1:0] gpa_cmp_o,
  output logic gpb_cmp_o,
  output logic infrared_o,
  // System requests.
  output logic irq_o,
  output logic [2:0] dma_req_o
);
  import gpt_pkg::*;

  // The register and channel logic assumes the documented widths at most.
  if (GPW < 2 || GPW > GP_W || BTW < 2 || BTW > BT_W)
  begin : g_chk
    $error("gpt_top: unsupported counter width");
  end

  // Address match, used by every register write decode; reads use the case below.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Power-of-two mask for a prescaler exponent.
  function automatic logic [BT_PSC_W-1:0] pmask(input logic [3:0] e);
    logic [BT_PSC_W:0] one;
    one = {{BT_PSC_W{1'b0}}, 1'b1};
    pmask = BT_PSC_W'((one << e) - one);
  endfunction

  logic wr, brkq_r, brk_rise;
  logic [7:0] ctrl_r [NGP], ctrl_nxt [NGP];
  logic [GPW-1:0] arr_r [NGP], arr_nxt [NGP], cnt_r [NGP], cnt_nxt [NGP];
  logic [GPW-1:0] ccr_r [NGP][2], ccr_nxt [NGP][2];
  logic [CCM_W-1:0] ccm_r [NGP], ccm_nxt [NGP];
  logic [GP_PSC_W-1:0] psc_r [NGP], psc_nxt [NGP];
  logic [1:0] cmp_r [NGP], cmp_nxt [NGP], capq_r [NGP], cap_in [NGP];
  logic trgq_r [NGP], trg_in [NGP];
  logic [EV_N-1:0] ev [NGP];

  // A write takes effect at the edge that completes the access phase.
  assign wr = psel_i & penable_i & pwrite_i & pready_o;
  assign brk_rise = break_i & ~brkq_r;
  assign cap_in[0] = gpa_cap_i;
  assign cap_in[1] = {1'b0, gpb_cap_i};
  // Timer b is slaved to the overflow of timer a.
  assign trg_in[0] = gp_timer_a_ext_trigger_i;
  assign trg_in[1] = ev[0][EV_OVF];

  // One general-purpose timer per pass; timer b has a single channel.
  for (genvar g = 0; g < NGP; g++)
  begin : g_gp
    localparam int NCH = (g == 0) ? 2 : 1;
    localparam logic [7:0] BASE = 8'(g * GP_STRIDE);

    // Next state of counter, prescaler, channels and control.
    always_comb
    begin
      logic trg_rise, run, tick, match, down;
      logic [BT_PSC_W-1:0] m;
      gpt_sync_e sm;
      gpt_chm_e cm;
      // Decodes of registers and the trigger input come first, so no local is ever left unset.
      trg_rise = trg_in[g] & ~trgq_r[g];
      sm = gpt_sync_e'(ctrl_r[g][SYNC_LSB+:3]);
      down = ctrl_r[g][CTRL_DOWN];
      run = ctrl_r[g][CTRL_EN] & (sm != SYNC_GATE || trg_in[g]);
      m = pmask({1'b0, ctrl_r[g][PSC_LSB+:PSC_W]});
      tick = 1'b0;
      match = 1'b0;
      cm = CH_OFF;
      ctrl_nxt[g] = ctrl_r[g];
      arr_nxt[g] = arr_r[g];
      ccm_nxt[g] = ccm_r[g];
      cmp_nxt[g] = cmp_r[g];
      ccr_nxt[g] = ccr_r[g];
      ev[g] = '0;
      if (wr && hit(paddr_i, BASE + OFS_CTRL))
        ctrl_nxt[g] = pwdata_i[CTRL_W-1:0];
      if (wr && hit(paddr_i, BASE + OFS_ARR))
        arr_nxt[g] = pwdata_i[GPW-1:0];
      if (wr && hit(paddr_i, BASE + OFS_CCM))
        ccm_nxt[g] = pwdata_i[CCM_W-1:0];
      // A trigger start sets the enable even against a software clear.
      if (sm == SYNC_START && trg_rise)
        ctrl_nxt[g][CTRL_EN] = 1'b1;
      psc_nxt[g] = run ? psc_r[g] + 1'b1 : psc_r[g];
      if (sm == SYNC_EXTCLK)
        tick = ctrl_r[g][CTRL_EN] & trg_rise;
      else
        tick = run && ((psc_r[g] & m[GP_PSC_W-1:0]) == m[GP_PSC_W-1:0]);
      cnt_nxt[g] = cnt_r[g];
      if (tick)
      begin
        if (down)
        begin
          ev[g][EV_OVF] = (cnt_r[g] == '0);
          cnt_nxt[g] = ev[g][EV_OVF] ? arr_r[g] : cnt_r[g] - 1'b1;
        end
        else
        begin
          ev[g][EV_OVF] = (cnt_r[g] >= arr_r[g]);
          cnt_nxt[g] = ev[g][EV_OVF] ? '0 : cnt_r[g] + 1'b1;
        end
      end
      if (sm == SYNC_RESET && trg_rise)
      begin
        cnt_nxt[g] = down ? arr_r[g] : '0;
        psc_nxt[g] = '0;
      end
      ev[g][EV_TRG] = trg_rise & (sm != SYNC_NONE);
      ev[g][EV_BRK] = brk_rise;
      // Each channel follows its own two mode bits.
      for (int c = 0; c < NCH; c++)
      begin
        cm = gpt_chm_e'(ccm_r[g][2*c+:2]);
        match = tick && (cnt_r[g] == ccr_r[g][c]);
        if (wr && hit(paddr_i, BASE + OFS_CC0 + 8'(4 * c)) && cm != CH_CAPTURE)
          ccr_nxt[g][c] = pwdata_i[GPW-1:0];
        unique case (cm)
          CH_OFF:
            cmp_nxt[g][c] = 1'b0;
          CH_TOGGLE:
          begin
            ev[g][EV_CC0+c] = match;
            cmp_nxt[g][c] = cmp_r[g][c] ^ match;
          end
          CH_PWM:
          begin
            ev[g][EV_CC0+c] = match;
            cmp_nxt[g][c] = (cnt_nxt[g] < ccr_r[g][c]);
          end
          CH_CAPTURE:
          begin
            cmp_nxt[g][c] = 1'b0;
            if (cap_in[g][c] & ~capq_r[g][c])
            begin
              ccr_nxt[g][c] = cnt_r[g];
              ev[g][EV_CC0+c] = 1'b1;
            end
          end
        endcase
        // Break forces the pins to their safe low level.
        if (break_i)
          cmp_nxt[g][c] = 1'b0;
      end
    end

    // Timer state registers.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        ctrl_r[g] <= '0;
        arr_r[g] <= GPW'(GP_ARR_RST);
        cnt_r[g] <= '0;
        ccr_r[g][0] <= '0;
        ccr_r[g][1] <= '0;
        ccm_r[g] <= '0;
        psc_r[g] <= '0;
        cmp_r[g] <= '0;
        capq_r[g] <= '0;
        trgq_r[g] <= 1'b0;
      end
      else
      begin
        ctrl_r[g] <= ctrl_nxt[g];
        arr_r[g] <= arr_nxt[g];
        cnt_r[g] <= cnt_nxt[g];
        ccr_r[g] <= ccr_nxt[g];
        ccm_r[g] <= ccm_nxt[g];
        psc_r[g] <= psc_nxt[g];
        cmp_r[g] <= cmp_nxt[g];
        capq_r[g] <= cap_in[g];
        trgq_r[g] <= trg_in[g];
      end
    end
  end

  logic [BT_CTRL_W-1:0] bctrl_r, bctrl_nxt;
  logic [BTW-1:0] barr_r, barr_nxt, bcnt_r, bcnt_nxt;
  logic [BT_PSC_W-1:0] bpsc_r, bpsc_nxt;
  logic bovf;

  // Basic timer: up only, wide prescaler.
  always_comb
  begin
    logic [BT_PSC_W-1:0] bm;
    logic btick;
    bm = pmask(bctrl_r[BT_PSC_LSB+:BT_EXP_W]);
    btick = bctrl_r[CTRL_EN] && ((bpsc_r & bm) == bm);
    bctrl_nxt = bctrl_r;
    barr_nxt = barr_r;
    if (wr && hit(paddr_i, BT_CTRL))
      bctrl_nxt = pwdata_i[BT_CTRL_W-1:0];
    if (wr && hit(paddr_i, BT_ARR))
      barr_nxt = pwdata_i[BTW-1:0];
    bpsc_nxt = bctrl_r[CTRL_EN] ? bpsc_r + 1'b1 : bpsc_r;
    bovf = btick && (bcnt_r >= barr_r);
    bcnt_nxt = bcnt_r;
    if (btick)
      bcnt_nxt = bovf ? '0 : bcnt_r + 1'b1;
  end

  // Basic timer registers.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bctrl_r <= '0;
      barr_r <= BTW'(BT_ARR_RST);
      bcnt_r <= '0;
      bpsc_r <= '0;
    end
    else
    begin
      bctrl_r <= bctrl_nxt;
      barr_r <= barr_nxt;
      bcnt_r <= bcnt_nxt;
      bpsc_r <= bpsc_nxt;
    end
  end

  logic [ST_W-1:0] st_r, st_nxt, ien_r, ien_nxt, evs;
  logic [2:0] dmae_r, dmae_nxt, dma_nxt;
  logic [31:0] rd;
  logic map;

  // Status, interrupt, DMA and bus answer; a new event beats a clear.
  always_comb
  begin
    evs = {bovf, ev[1], ev[0]};
    ien_nxt = ien_r;
    dmae_nxt = dmae_r;
    if (wr && hit(paddr_i, REG_IEN))
      ien_nxt = pwdata_i[ST_W-1:0];
    if (wr && hit(paddr_i, REG_DMA))
      dmae_nxt = pwdata_i[2:0];
    st_nxt = st_r;
    if (wr && hit(paddr_i, REG_ICLR))
      st_nxt = st_r & ~pwdata_i[ST_W-1:0];
    st_nxt = st_nxt | evs;
    dma_nxt = dmae_r & {bovf, ev[1][EV_OVF], ev[0][EV_OVF]};
    map = 1'b1;
    rd = '0;
    unique case (paddr_i)
      OFS_CTRL: rd = 32'(ctrl_r[0]);
      OFS_ARR: rd = 32'(arr_r[0]);
      OFS_CNT: rd = 32'(cnt_r[0]);
      OFS_CC0: rd = 32'(ccr_r[0][0]);
      OFS_CC1: rd = 32'(ccr_r[0][1]);
      OFS_CCM: rd = 32'(ccm_r[0]);
      GP_STRIDE + OFS_CTRL: rd = 32'(ctrl_r[1]);
      GP_STRIDE + OFS_ARR: rd = 32'(arr_r[1]);
      GP_STRIDE + OFS_CNT: rd = 32'(cnt_r[1]);
      GP_STRIDE + OFS_CC0: rd = 32'(ccr_r[1][0]);
      GP_STRIDE + OFS_CCM: rd = 32'(ccm_r[1] & 4'h3);
      BT_CTRL: rd = 32'(bctrl_r);
      BT_ARR: rd = 32'(barr_r);
      BT_CNT: rd = 32'(bcnt_r);
      REG_STAT: rd = 32'(st_r);
      REG_IEN: rd = 32'(ien_r);
      REG_ICLR: rd = '0;
      REG_DMA: rd = 32'(dmae_r);
      default: map = 1'b0;
    endcase
  end

  // Bus and system outputs; one wait state keeps every output registered.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= '0;
      ien_r <= '0;
      dmae_r <= '0;
      dma_req_o <= '0;
      irq_o <= 1'b0;
      brkq_r <= 1'b0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
      gpa_cmp_o <= '0;
      gpb_cmp_o <= 1'b0;
      infrared_o <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      ien_r <= ien_nxt;
      dmae_r <= dmae_nxt;
      dma_req_o <= dma_nxt;
      irq_o <= |(st_nxt & ien_nxt);
      brkq_r <= break_i;
      pready_o <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~map;
      if (psel_i & penable_i & ~pready_o & ~pwrite_i)
        prdata_o <= rd;
      gpa_cmp_o <= cmp_nxt[0];
      gpb_cmp_o <= cmp_nxt[1][0];
      // Carrier from timer a channel 0 gated by envelope of timer b.
      infrared_o <= cmp_nxt[0][0] & cmp_nxt[1][0];
    end
  end
endmodule // gpt_top
`default_nettype wire

// ### test/gpt_chk_sva.sv
// Assertion checker on the ports of the timer set.
`default_nettype none
module gpt_chk (
  // Clock, reset and register bus.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Timer pins and requests.
  input wire logic break_i,
  input wire logic [1:0] gpa_cmp_o,
  input wire logic gpb_cmp_o,
  input wire logic infrared_o,
  input wire logic irq_o,
  input wire logic [2:0] dma_req_o
);
  // One clock domain, so the clock and reset are given once.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready not after one wait state");
  a_ready_req: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready without access phase");
  a_idle_quiet: assert property (!psel_i |=> !pready_o)
    else $error("ready while idle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_err_rdzero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_brk_quiet: assert property (break_i [*3] |-> gpa_cmp_o == 2'h0 && !gpb_cmp_o)
    else $error("compare output during break");
  a_ir_pair: assert property (infrared_o == (gpa_cmp_o[0] && gpb_cmp_o))
    else $error("infrared not the pair of both channels");
  a_reset_quiet: assert property ($rose(rst_b_i) |-> !irq_o && dma_req_o == 3'h0)
    else $error("request right after reset");
  // Main scenarios that the bench should reach.
  c_err: cover property (pslverr_o);
  c_ir: cover property (infrared_o);
  c_bt_dma: cover property (dma_req_o[2]);
endmodule // gpt_chk
bind gpt_top gpt_chk gpt_chk_inst (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
  .prdata_o, .pready_o, .pslverr_o, .break_i, .gpa_cmp_o, .gpb_cmp_o, .infrared_o,
  .irq_o, .dma_req_o);
`default_nettype wire

// ### test/gpt_pins.sv
// Board model that drives the trigger, break and capture pins of the timer set.
`default_nettype none
module gpt_pins (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Requests: [0] trigger, [1] break, [3:2] capture a, [4] capture b.
  input wire logic [4:0] req_i,
  // Pin levels.
  output logic trig_o,
  output logic brk_o,
  output logic [1:0] cap_a_o,
  output logic cap_b_o
);
  logic [4:0] d1_r, d2_r, d3_r;
  // A request becomes a three-cycle level, so any edge sampler sees one clean rise.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      {d3_r, d2_r, d1_r} <= 15'h0;
    else
      {d3_r, d2_r, d1_r} <= {d2_r, d1_r, req_i};
  end
  // Pins idle low between pulses.
  assign {cap_b_o, cap_a_o, brk_o, trig_o} = d1_r | d2_r | d3_r;
endmodule // gpt_pins
`default_nettype wire

// ### test/gpt_top_tb.sv
// Self-checking bench for the timer set.
`default_nettype none
module gpt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpt_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} gpt_row_s;
  logic clk, rst_b, psel, pen, pwr, prdy, perr, irq, ir, brk, trg, capb, cmpb, e;
  logic [7:0] paddr;
  logic [31:0] pwd, prd, q, c0;
  logic [1:0] capa, cmpa;
  logic [2:0] dma;
  logic [4:0] req;
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] na, nb, ni, nt;
  logic [31:0] md [3] = '{32'h1, 32'h3, 32'h1F};
  logic [31:0] pd [3] = '{32'h5, 32'h5, 32'h280};
  gpt_row_s rows [5] = '{
    '{OFS_ARR, 32'h1_2345, 32'h2345, 1'b0},
    '{BT_ARR, 32'h1FF, 32'hFF, 1'b0},
    '{GP_STRIDE + OFS_CCM, 32'hF, 32'h3, 1'b0},
    '{REG_IEN, 32'hFFFF_FFFF, 32'h7FF, 1'b0},
    '{8'h60, 32'h1, 32'h0, 1'b1}};
  gpt_top gpt_top_inst (.mclk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .gp_timer_a_ext_trigger_i(trg), .break_i(brk), .gpa_cap_i(capa),
    .gpb_cap_i(capb), .gpa_cmp_o(cmpa), .gpb_cmp_o(cmpb), .infrared_o(ir), .irq_o(irq),
    .dma_req_o(dma));
  gpt_pins gpt_pins_inst (.mclk_i(clk), .rst_b_i(rst_b), .req_i(req), .trig_o(trg),
    .brk_o(brk), .cap_a_o(capa), .cap_b_o(capb));
  // Compare one value and keep the tallies.
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    n_checks++;
    if (y !== x)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask
  // One bus transfer; the request stands until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwr, paddr, pwd} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    {q, e} = {prd, perr};
    {psel, pen} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask
  // Cycles between two overflow requests on one line.
  task automatic per(input int b, input logic [31:0] x);
    logic [31:0] n;
    int k;
    {n, k} = 0;
    while (k < 2 && n < 32'h1_2000)
    begin
      @(posedge clk);
      k += dma[b];
      n += (k > 0);
    end
    chk("period", x, n - 32'h1);
  endtask
  // Ask the board model for one pin pulse and let it finish.
  task automatic pulse(input logic [4:0] b);
    req <= b;
    @(posedge clk);
    req <= 5'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Free-running clock at 50 MHz.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The longest wait is two basic periods of 32768 cycles; 90000 cycles leave room for the rest.
  initial
  begin
    #1.8ms;
    num_errors++;
    stop_test();
  end
  // Main sequence.
  initial
  begin
    {rst_b, psel, pen, pwr, paddr, pwd, req} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      rd("row data", rows[i].a, rows[i].x);
      chk("row error", {31'h0, rows[i].e}, {31'h0, e});
    end
    $display("test rows done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd("reload a", OFS_ARR, 32'hFFFF);
    rd("reload basic", BT_ARR, 32'hFF);
    $display("test reset done");
    apb(1'b1, REG_DMA, 32'h7);
    apb(1'b1, BT_ARR, 32'h3);
    apb(1'b1, BT_CTRL, 32'h1);
    per(2, 32'h4);
    apb(1'b1, BT_CTRL, 32'h5);
    per(2, 32'h10);
    apb(1'b1, BT_ARR, 32'h0);
    apb(1'b1, BT_CTRL, 32'h1F);
    per(2, 32'h8000);
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'b1, REG_IEN, 32'h400);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, BT_CTRL, 32'h0);
    apb(1'b1, REG_ICLR, 32'h7FF);
    @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test basic timer done");
    apb(1'b1, OFS_ARR, 32'h4);
    foreach (md[i])
    begin
      apb(1'b1, OFS_CTRL, md[i]);
      per(0, pd[i]);
    end
    apb(1'b1, OFS_CC0, 32'h2);
    apb(1'b1, OFS_CC1, 32'h3);
    apb(1'b1, OFS_CCM, 32'h6);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, GP_STRIDE + OFS_ARR, 32'h4);
    apb(1'b1, GP_STRIDE + OFS_CC0, 32'h5);
    apb(1'b1, GP_STRIDE + OFS_CCM, 32'h2);
    apb(1'b1, GP_STRIDE + OFS_CTRL, 32'h1);
    per(1, 32'h5);
    {na, nb, ni, nt} = 0;
    repeat (10)
    begin
      @(posedge clk);
      {na, nb, ni, nt} = {na + cmpa[0], nb + cmpb, ni + ir, nt + cmpa[1]};
    end
    chk("pwm a", 32'h4, na);
    chk("pwm b", 32'hA, nb);
    chk("infrared", 32'h4, ni);
    chk("toggle a", 32'h5, nt);
    pulse(5'h02);
    $display("test gp timers done");
    apb(1'b1, GP_STRIDE + OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_ARR, 32'hFFFF);
    apb(1'b1, OFS_CCM, 32'hC);
    apb(1'b1, OFS_CTRL, 32'h21);
    apb(1'b1, REG_ICLR, 32'h7FF);
    apb(1'b0, OFS_CNT, 32'h0);
    c0 = q;
    repeat (3) pulse(5'h01);
    rd("ext count", OFS_CNT, c0 + 32'h3);
    pulse(5'h08);
    rd("capture", OFS_CC1, c0 + 32'h3);
    pulse(5'h02);
    rd("status", REG_STAT, 32'h21C);
    // Gate mode counts only the three cycles in which the trigger stands high.
    apb(1'b1, OFS_CTRL, 32'h61);
    apb(1'b0, OFS_CNT, 32'h0);
    c0 = q;
    pulse(5'h01);
    rd("gated count", OFS_CNT, c0 + 32'h3);
    // The rise clears the count at the pulse's second edge; six ticks pass before the load.
    apb(1'b1, OFS_CTRL, 32'h41);
    pulse(5'h01);
    rd("reset count", OFS_CNT, 32'h6);
    apb(1'b1, OFS_CTRL, 32'h80);
    pulse(5'h01);
    rd("start enable", OFS_CTRL, 32'h81);
    // Timer b stands still, so its capture must hold the count just read.
    apb(1'b1, GP_STRIDE + OFS_CCM, 32'h3);
    apb(1'b0, GP_STRIDE + OFS_CNT, 32'h0);
    c0 = q;
    pulse(5'h10);
    rd("capture b", GP_STRIDE + OFS_CC0, c0);
    $display("test trigger done");
    stop_test();
  end
endmodule // gpt_top_tb
`default_nettype wire
